// ### hdl/lock_qualifier.sv
`timescale 1ns/1ps
module lock_qualifier #(
  parameter int CNT_W = 16,
  parameter int WIN_W = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             clkEn,
  input  wire logic             pdTick,
  input  wire logic [WIN_W-1:0] phaseErr,
  input  wire logic [WIN_W-1:0] window,
  input  wire logic [CNT_W-1:0] qualCount,
  output logic                  lockDetect
);
  logic [CNT_W-1:0] runLen;
  logic [CNT_W-1:0] next_runLen;
  logic             next_lockDetect;
  logic             inWindow;

  always_comb
  begin
    inWindow        = (phaseErr <= window);
    next_runLen     = runLen;
    next_lockDetect = lockDetect;
    if (pdTick)
    begin
      if (!inWindow)
      begin
        next_runLen     = '0;
        next_lockDetect = 1'b0;
      end
      else if (runLen >= qualCount)
        next_lockDetect = 1'b1;
      else
        next_runLen = runLen + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      runLen     <= '0;
      lockDetect <= 1'b0;
    end
    else if (clkEn)
    begin
      runLen     <= next_runLen;
      lockDetect <= next_lockDetect;
    end
  end
endmodule

// ### hdl/pll_lock_detect_holdover_ctrl.sv
`timescale 1ns/1ps
module pll_lock_detect_holdover_ctrl #(
  parameter int DAC_W = 10,
  parameter int CNT_W = 16,
  parameter int WIN_W = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             clkEn,
  input  wire logic [3:0]       regAddr,
  input  wire logic [31:0]      regWdata,
  input  wire logic             regWr,
  input  wire logic             regRd,
  output logic      [31:0]      regRdata,
  input  wire logic             pdTick,
  input  wire logic [WIN_W-1:0] phaseErr,
  input  wire logic [DAC_W-1:0] tuneVoltageCode,
  input  wire logic             refValidPin,
  output logic                  lock_detect_out,
  output logic                  holdoverActive,
  output logic      [DAC_W-1:0] tuneDacCode,
  output logic                  tuneDacOverride,
  output logic      [10:0]      osc_buffer_out_divider,
  output logic      [1:0]       out3_vcxo_source_sel,
  output logic      [1:0]       out4VcxoSourceSel,
  output logic                  doublerEn,
  output logic      [7:0]       synthLoopRefDiv,
  output logic                  irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Reference valid synchroniser

  logic refSync1;
  logic refValid;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      refSync1 <= 1'b0;
      refValid <= 1'b0;
    end
    else if (clkEn)
    begin
      refSync1 <= refValidPin;
      refValid <= refSync1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  pll_supervisor_pkg::bus_req_s bus;
  pll_supervisor_pkg::ctrl_s    ctrl;
  pll_supervisor_pkg::ctrl_s    next_ctrl;
  logic [CNT_W-1:0]             qualCount;
  logic [CNT_W-1:0]             next_qualCount;
  logic [WIN_W-1:0]             window;
  logic [WIN_W-1:0]             next_window;
  logic [DAC_W-1:0]             manualCode;
  logic [DAC_W-1:0]             next_manualCode;
  logic [10:0]                  next_oscDiv;
  logic [1:0]                   next_out3Sel;
  logic [1:0]                   next_out4Sel;
  logic [pll_supervisor_pkg::IRQ_WIDTH-1:0] irqStat;
  logic [pll_supervisor_pkg::IRQ_WIDTH-1:0] next_irqStat;
  logic [pll_supervisor_pkg::IRQ_WIDTH-1:0] irqMask;
  logic [pll_supervisor_pkg::IRQ_WIDTH-1:0] next_irqMask;
  logic [pll_supervisor_pkg::IRQ_WIDTH-1:0] events;
  logic [31:0]                  next_rdata;
  logic [DAC_W-1:0]             trackedCode;
  pll_supervisor_pkg::hold_state_e state;

  assign bus.addr  = regAddr;
  assign bus.wdata = regWdata;
  assign bus.wr    = regWr;
  assign bus.rd    = regRd;

  always_comb
  begin
    next_ctrl       = ctrl;
    next_qualCount  = qualCount;
    next_window     = window;
    next_manualCode = manualCode;
    next_oscDiv     = osc_buffer_out_divider;
    next_out3Sel    = out3_vcxo_source_sel;
    next_out4Sel    = out4VcxoSourceSel;
    next_irqMask    = irqMask;
    next_irqStat    = irqStat;
    next_rdata      = 32'h0000_0000;
    if (bus.wr)
    begin
      case (bus.addr)
        pll_supervisor_pkg::ADDR_CTRL:
        begin
          next_ctrl.mode    = bus.wdata[pll_supervisor_pkg::CTRL_MODE_LSB +: 2];
          next_ctrl.track   = bus.wdata[pll_supervisor_pkg::CTRL_TRACK_BIT];
          next_ctrl.manDac  = bus.wdata[pll_supervisor_pkg::CTRL_MANDAC_BIT];
          next_ctrl.trigOff = bus.wdata[pll_supervisor_pkg::CTRL_TRIGOFF_BIT];
          next_ctrl.doubler = bus.wdata[pll_supervisor_pkg::CTRL_DOUBLER_BIT];
          next_ctrl.synthR  = bus.wdata[pll_supervisor_pkg::CTRL_SYNTHR_LSB +: 8];
        end
        pll_supervisor_pkg::ADDR_QUAL:    next_qualCount  = bus.wdata[CNT_W-1:0];
        pll_supervisor_pkg::ADDR_WINDOW:  next_window     = bus.wdata[WIN_W-1:0];
        pll_supervisor_pkg::ADDR_DAC:     next_manualCode = bus.wdata[DAC_W-1:0];
        pll_supervisor_pkg::ADDR_OSCDIV:  next_oscDiv     = bus.wdata[10:0];
        pll_supervisor_pkg::ADDR_OUTSEL:
        begin
          next_out3Sel = bus.wdata[1:0];
          next_out4Sel = bus.wdata[9:8];
        end
        pll_supervisor_pkg::ADDR_IRQMASK: next_irqMask = bus.wdata[pll_supervisor_pkg::IRQ_WIDTH-1:0];
        default:
        begin
        end
      endcase
    end
    if (bus.rd)
    begin
      case (bus.addr)
        pll_supervisor_pkg::ADDR_CTRL:
          next_rdata = {16'h0000, ctrl.synthR, 2'h0, ctrl.doubler, ctrl.trigOff,
                        ctrl.manDac, ctrl.track, ctrl.mode};
        pll_supervisor_pkg::ADDR_QUAL:    next_rdata = 32'(qualCount);
        pll_supervisor_pkg::ADDR_WINDOW:  next_rdata = 32'(window);
        pll_supervisor_pkg::ADDR_DAC:     next_rdata = 32'(manualCode);
        pll_supervisor_pkg::ADDR_OSCDIV:  next_rdata = 32'(osc_buffer_out_divider);
        pll_supervisor_pkg::ADDR_OUTSEL:
          next_rdata = {22'h000000, out4VcxoSourceSel, 6'h00, out3_vcxo_source_sel};
        pll_supervisor_pkg::ADDR_STATUS:
          next_rdata = {29'h0000000, refValid, state == pll_supervisor_pkg::ST_HOLDOVER, lock_detect_out};
        pll_supervisor_pkg::ADDR_IRQSTAT:
        begin
          next_rdata   = 32'(irqStat);
          next_irqStat = '0;
        end
        pll_supervisor_pkg::ADDR_IRQMASK: next_rdata = 32'(irqMask);
        pll_supervisor_pkg::ADDR_TRACKED: next_rdata = 32'(trackedCode);
        default:                          next_rdata = 32'h0000_0000;
      endcase
    end
    next_irqStat = next_irqStat | events;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl.mode              <= pll_supervisor_pkg::MODE_RESET;
      ctrl.track             <= 1'b0;
      ctrl.manDac            <= 1'b0;
      ctrl.trigOff           <= 1'b0;
      ctrl.doubler           <= 1'b0;
      ctrl.synthR            <= pll_supervisor_pkg::SYNTHR_RESET;
      qualCount              <= pll_supervisor_pkg::QUAL_RESET;
      window                 <= pll_supervisor_pkg::WINDOW_RESET;
      manualCode             <= pll_supervisor_pkg::DAC_MID_CODE;
      osc_buffer_out_divider <= pll_supervisor_pkg::OSCDIV_RESET;
      out3_vcxo_source_sel   <= '0;
      out4VcxoSourceSel      <= '0;
      irqMask                <= '0;
      irqStat                <= '0;
      regRdata               <= 32'h0000_0000;
    end
    else if (clkEn)
    begin
      ctrl                   <= next_ctrl;
      qualCount              <= next_qualCount;
      window                 <= next_window;
      manualCode             <= next_manualCode;
      osc_buffer_out_divider <= next_oscDiv;
      out3_vcxo_source_sel   <= next_out3Sel;
      out4VcxoSourceSel      <= next_out4Sel;
      irqMask                <= next_irqMask;
      irqStat                <= next_irqStat;
      regRdata               <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lock detection

  logic lockNow;
  logic lockPrev;

  lock_qualifier #(
    .CNT_W (CNT_W),
    .WIN_W (WIN_W)
  ) u_qual (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .clkEn      (clkEn),
    .pdTick     (pdTick),
    .phaseErr   (phaseErr),
    .window     (window),
    .qualCount  (qualCount),
    .lockDetect (lockNow)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Holdover control

  pll_supervisor_pkg::hold_state_e next_state;
  logic [DAC_W-1:0]                next_trackedCode;
  logic [DAC_W-1:0]                next_dacCode;
  logic                            next_override;
  logic                            holdEnabled;

  always_comb
  begin
    holdEnabled      = (ctrl.mode == pll_supervisor_pkg::HOLDOVER_MODE_EN);
    next_state       = state;
    next_trackedCode = trackedCode;
    next_dacCode     = tuneDacCode;
    next_override    = 1'b0;
    events           = '0;
    events[pll_supervisor_pkg::IRQ_LOCK_GAIN] = lockNow & ~lockPrev;
    events[pll_supervisor_pkg::IRQ_LOCK_LOSS] = ~lockNow & lockPrev;
    case (state)
      pll_supervisor_pkg::ST_LOCKING:
        if (lockNow)
          next_state = pll_supervisor_pkg::ST_LOCKED;
      pll_supervisor_pkg::ST_LOCKED:
      begin
        if (ctrl.track)
          next_trackedCode = tuneVoltageCode;
        if (!lockNow && holdEnabled && !ctrl.trigOff)
        begin
          next_state = pll_supervisor_pkg::ST_HOLDOVER;
          events[pll_supervisor_pkg::IRQ_HOLD_ENTER] = 1'b1;
        end
        else if (!lockNow)
          next_state = pll_supervisor_pkg::ST_LOCKING;
      end
      pll_supervisor_pkg::ST_HOLDOVER:
      begin
        next_override = 1'b1;
        next_dacCode  = ctrl.manDac ? manualCode : trackedCode;
        if (refValid || !holdEnabled)
        begin
          next_state    = pll_supervisor_pkg::ST_LOCKING;
          next_override = 1'b0;
          events[pll_supervisor_pkg::IRQ_HOLD_EXIT] = 1'b1;
        end
      end
      default: next_state = pll_supervisor_pkg::ST_LOCKING;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state           <= pll_supervisor_pkg::ST_LOCKING;
      trackedCode     <= pll_supervisor_pkg::DAC_MID_CODE;
      tuneDacCode     <= pll_supervisor_pkg::DAC_MID_CODE;
      tuneDacOverride <= 1'b0;
      lockPrev        <= 1'b0;
      lock_detect_out <= 1'b0;
      holdoverActive  <= 1'b0;
      doublerEn       <= 1'b0;
      synthLoopRefDiv <= pll_supervisor_pkg::SYNTHR_RESET;
      irq             <= 1'b0;
    end
    else if (clkEn)
    begin
      state           <= next_state;
      trackedCode     <= next_trackedCode;
      tuneDacCode     <= next_dacCode;
      tuneDacOverride <= next_override;
      lockPrev        <= lockNow;
      lock_detect_out <= lockNow;
      holdoverActive  <= (next_state == pll_supervisor_pkg::ST_HOLDOVER);
      doublerEn       <= ctrl.doubler;
      synthLoopRefDiv <= ctrl.synthR;
      irq             <= |(next_irqStat & irqMask);
    end
  end
endmodule

// ### hdl/pll_supervisor_pkg.sv
// Operation
// - Oscillator buffer output divider holds one after power-on reset.
// - Lock detect asserts after qualifying count of consecutive in-window cycles.
// - Lock detect deasserts whenever phase difference leaves the window.
// - With trigger-off bit zero, lock loss enters holdover.
// - Valid reference ends holdover; reference loop resumes locking.
// - Holdover mode field value two enables holdover.
// - Tracking bit zero stops tracking tuning voltage as holdover value.
// - Manual DAC enable one drives holdover voltage from manual code.
// - Manual DAC code 512 gives about half supply.
// - Output three select 0x01 routes the VCXO input clock.
// - Outputs three and four each have a VCXO source mux.
package pll_supervisor_pkg;

  localparam logic [3:0] ADDR_CTRL     = 4'h0;
  localparam logic [3:0] ADDR_QUAL     = 4'h1;
  localparam logic [3:0] ADDR_WINDOW   = 4'h2;
  localparam logic [3:0] ADDR_DAC      = 4'h3;
  localparam logic [3:0] ADDR_OSCDIV   = 4'h4;
  localparam logic [3:0] ADDR_OUTSEL   = 4'h5;
  localparam logic [3:0] ADDR_STATUS   = 4'h6;
  localparam logic [3:0] ADDR_IRQSTAT  = 4'h7;
  localparam logic [3:0] ADDR_IRQMASK  = 4'h8;
  localparam logic [3:0] ADDR_TRACKED  = 4'h9;

  localparam int CTRL_MODE_LSB   = 0;
  localparam int CTRL_TRACK_BIT  = 2;
  localparam int CTRL_MANDAC_BIT = 3;
  localparam int CTRL_TRIGOFF_BIT = 4;
  localparam int CTRL_DOUBLER_BIT = 5;
  localparam int CTRL_SYNTHR_LSB = 8;

  localparam logic [1:0]  HOLDOVER_MODE_EN  = 2'h2;
  localparam logic [1:0]  OUTSEL_VCXO       = 2'h1;
  localparam logic [9:0]  DAC_MID_CODE      = 10'h200;
  localparam logic [10:0] OSCDIV_RESET      = 11'h001;
  localparam logic [15:0] QUAL_RESET        = 16'h2710;
  localparam logic [7:0]  WINDOW_RESET      = 8'h04;
  localparam logic [1:0]  MODE_RESET        = 2'h0;
  localparam logic [7:0]  SYNTHR_RESET      = 8'h01;

  localparam int IRQ_LOCK_GAIN  = 0;
  localparam int IRQ_LOCK_LOSS  = 1;
  localparam int IRQ_HOLD_ENTER = 2;
  localparam int IRQ_HOLD_EXIT  = 3;
  localparam int IRQ_WIDTH      = 4;

  typedef enum logic [1:0] {ST_LOCKING, ST_LOCKED, ST_HOLDOVER} hold_state_e;

  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_s;

  typedef struct packed {
    logic [1:0] mode;
    logic       track;
    logic       manDac;
    logic       trigOff;
    logic       doubler;
    logic [7:0] synthR;
  } ctrl_s;

endpackage

// ### tb/pd_vcxo_model.sv
`timescale 1ns/1ps
module pd_vcxo_model (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       settled,
  input  wire logic       refOk,
  output logic            pdTick,
  output logic      [7:0] phaseErr,
  output logic      [9:0] tuneVoltageCode,
  output logic            refValidPin
);
  logic [1:0] div;
  // Phase detector ticks every fourth cycle; the tuning voltage drifts each tick
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      div             <= 2'h0;
      pdTick          <= 1'b0;
      phaseErr        <= 8'hFF;
      tuneVoltageCode <= 10'h155;
    end
    else
    begin
      div    <= div + 2'h1;
      pdTick <= (div == 2'h3);
      if (div == 2'h3)
      begin
        phaseErr        <= settled ? {6'h00, tuneVoltageCode[1:0]} : (8'h80 | tuneVoltageCode[7:0]);
        tuneVoltageCode <= tuneVoltageCode + 10'h001;
      end
    end
  assign refValidPin = refOk;
endmodule

// ### tb/pll_supervisor_monitor.sv
`timescale 1ns/1ps
module pll_supervisor_monitor #(
  parameter int DAC_W = 10,
  parameter int WIN_W = 8
) (
  input wire logic             clk_sys,
  input wire logic             rst_n,
  input wire logic             clkEn,
  input wire logic [3:0]       regAddr,
  input wire logic [31:0]      regWdata,
  input wire logic             regWr,
  input wire logic             pdTick,
  input wire logic [WIN_W-1:0] phaseErr,
  input wire logic             refValidPin,
  input wire logic             lock_detect_out,
  input wire logic             holdoverActive,
  input wire logic [DAC_W-1:0] tuneDacCode,
  input wire logic             tuneDacOverride,
  input wire logic [10:0]      osc_buffer_out_divider,
  input wire logic [1:0]       out3_vcxo_source_sel,
  input wire logic [1:0]       out4VcxoSourceSel,
  input wire logic [7:0]       synthLoopRefDiv,
  input wire logic             irq
);
  logic [WIN_W-1:0] win;
  logic [15:0]      qual;
  logic [DAC_W-1:0] dac;
  logic [4:0]       ctrl;
  logic [16:0]      runCnt;
  logic [31:0]      lastWd;
  ////////////////////////////////////////////////////////////////////////////////
  // Shadow of the window, qualifying count, DAC code and control registers, and a run counter of in-window ticks
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      win    <= pll_supervisor_pkg::WINDOW_RESET;
      qual   <= pll_supervisor_pkg::QUAL_RESET;
      dac    <= pll_supervisor_pkg::DAC_MID_CODE;
      ctrl   <= 5'h00;
      runCnt <= 17'h00000;
      lastWd <= 32'h00000000;
    end
    else if (clkEn)
    begin
      lastWd <= regWdata;
      if (regWr && regAddr == pll_supervisor_pkg::ADDR_WINDOW) win <= regWdata[WIN_W-1:0];
      if (regWr && regAddr == pll_supervisor_pkg::ADDR_QUAL) qual <= regWdata[15:0];
      if (regWr && regAddr == pll_supervisor_pkg::ADDR_DAC) dac <= regWdata[DAC_W-1:0];
      if (regWr && regAddr == pll_supervisor_pkg::ADDR_CTRL) ctrl <= regWdata[4:0];
      if (pdTick) runCnt <= (phaseErr <= win) ? runCnt + 17'h00001 : 17'h00000;
    end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_div_reset;
    $rose(rst_n) |-> osc_buffer_out_divider == 11'h001 && synthLoopRefDiv == 8'h01;
  endproperty
  property p_lock_rise;
    $rose(lock_detect_out) |-> runCnt >= {1'b0, qual} + 17'h00001;
  endproperty
  property p_lock_drop;
    lock_detect_out && clkEn && pdTick && phaseErr > win |-> ##[1:2] !lock_detect_out;
  endproperty
  property p_hold_enter;
    $fell(lock_detect_out) && ctrl[1:0] == 2'h2 && !ctrl[4] && !refValidPin && !$past(refValidPin, 4)
      |-> ##[0:3] holdoverActive;
  endproperty
  property p_hold_block;
    (ctrl[4] || ctrl[1:0] != 2'h2) && !holdoverActive |=> !holdoverActive;
  endproperty
  property p_hold_exit;
    (holdoverActive && refValidPin) [*3] |-> ##[0:3] !holdoverActive;
  endproperty
  property p_override;
    $rose(holdoverActive) |-> ##[0:1] tuneDacOverride;
  endproperty
  property p_manual_tune_dac_code;
    holdoverActive && $past(holdoverActive, 2) && ctrl[3] |-> tuneDacCode == dac;
  endproperty
  property p_no_track;
    holdoverActive && $past(holdoverActive, 2) && !ctrl[3] && !ctrl[2] |-> $stable(tuneDacCode);
  endproperty
  property p_outsel;
    regWr && clkEn && regAddr == pll_supervisor_pkg::ADDR_OUTSEL
      |=> out3_vcxo_source_sel == lastWd[1:0] && out4VcxoSourceSel == lastWd[9:8];
  endproperty
  a_div_reset: assert property (p_div_reset) else $error("divider not one after reset");
  a_lock_rise: assert property (p_lock_rise) else $error("lock rose before qualifying run");
  a_lock_drop: assert property (p_lock_drop) else $error("lock held after out-of-window tick");
  a_hold_enter: assert property (p_hold_enter) else $error("holdover not entered on lock loss");
  a_hold_block: assert property (p_hold_block) else $error("holdover entered while disabled");
  a_hold_exit: assert property (p_hold_exit) else $error("holdover kept with valid reference");
  a_override: assert property (p_override) else $error("tuning override missing in holdover");
  a_manual_tune_dac_code: assert property (p_manual_tune_dac_code) else $error("holdover code not manual code");
  a_no_track: assert property (p_no_track) else $error("holdover code tracks tuning voltage");
  a_outsel: assert property (p_outsel) else $error("output source select wrong");
  c_lock: cover property ($rose(lock_detect_out));
  c_hold: cover property ($rose(holdoverActive));
  c_irq: cover property ($rose(irq));
endmodule
bind pll_lock_detect_holdover_ctrl pll_supervisor_monitor #(.DAC_W(DAC_W), .WIN_W(WIN_W)) u_pll_supervisor_monitor (
  .clk_sys(clk_sys), .rst_n(rst_n), .clkEn(clkEn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
  .pdTick(pdTick), .phaseErr(phaseErr), .refValidPin(refValidPin), .lock_detect_out(lock_detect_out),
  .holdoverActive(holdoverActive), .tuneDacCode(tuneDacCode), .tuneDacOverride(tuneDacOverride),
  .osc_buffer_out_divider(osc_buffer_out_divider), .out3_vcxo_source_sel(out3_vcxo_source_sel),
  .out4VcxoSourceSel(out4VcxoSourceSel), .synthLoopRefDiv(synthLoopRefDiv), .irq(irq));

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic        clk_sys, rst_n, regWr, regRd, settled, refOk, pdTick, refValidPin, clkEn, prevHold;
  logic        lock_detect_out, holdoverActive, tuneDacOverride, doublerEn, irq;
  logic [3:0]  regAddr, c;
  logic [31:0] regWdata, regRdata, rdv;
  logic [7:0]  phaseErr, synthLoopRefDiv;
  logic [9:0]  tuneVoltageCode, tuneDacCode;
  logic [10:0] osc_buffer_out_divider;
  logic [1:0]  out3_vcxo_source_sel, out4VcxoSourceSel;
  logic [15:0] seed;
  logic [3:0]  cases [6] = '{4'h8, 4'h9, 4'hB, 4'hE, 4'hA, 4'h2};
  int          errors, n_compared;
  pll_lock_detect_holdover_ctrl u_pll_lock_detect_holdover_ctrl (
    .clk_sys(clk_sys), .rst_n(rst_n), .clkEn(clkEn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .pdTick(pdTick), .phaseErr(phaseErr), .tuneVoltageCode(tuneVoltageCode),
    .refValidPin(refValidPin), .lock_detect_out(lock_detect_out), .holdoverActive(holdoverActive),
    .tuneDacCode(tuneDacCode), .tuneDacOverride(tuneDacOverride), .osc_buffer_out_divider(osc_buffer_out_divider),
    .out3_vcxo_source_sel(out3_vcxo_source_sel), .out4VcxoSourceSel(out4VcxoSourceSel), .doublerEn(doublerEn),
    .synthLoopRefDiv(synthLoopRefDiv), .irq(irq));
  pd_vcxo_model u_pd_vcxo_model (.clk_sys(clk_sys), .rst_n(rst_n), .settled(settled), .refOk(refOk),
    .pdTick(pdTick), .phaseErr(phaseErr), .tuneVoltageCode(tuneVoltageCode), .refValidPin(refValidPin));
  ////////////////////////////////////////////////////////////////////////////////
  function logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Case word: [3] manual code, [2] trigger off, [1:0] holdover mode
  function logic expHold(input logic [3:0] k);
    return k[1:0] == pll_supervisor_pkg::HOLDOVER_MODE_EN && !k[2];
  endfunction
  function logic [3:0] expIrq(input logic [3:0] k);
    return {1'b0, expHold(k), 2'b10};
  endfunction
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    @(negedge clk_sys);
    d = regRdata;
  endtask
  task waitLock(input logic v);
    for (int k = 0; k < 200 && lock_detect_out !== v; k++) @(negedge clk_sys);
  endtask
  task stop_test;
    if (errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial
  begin
    #1000000;
    errors++;
    stop_test();
  end
  initial
  begin
    {rst_n, regWr, regRd, settled, refOk, prevHold, regAddr, regWdata} = '0;
    clkEn = 1'b1;
    seed = 16'h3914;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    chk("divider", 11'h001, osc_buffer_out_divider);
    @(posedge clk_sys);
    clkEn <= 1'b0;
    wr(pll_supervisor_pkg::ADDR_OSCDIV, 32'h00000002);
    clkEn <= 1'b1;
    @(negedge clk_sys);
    chk("frozen", 11'h001, osc_buffer_out_divider);
    wr(pll_supervisor_pkg::ADDR_CTRL, 32'h00000220);
    repeat (2) @(negedge clk_sys);
    chk("doubler", 1'b1, doublerEn);
    chk("refdiv", 8'h02, synthLoopRefDiv);
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      wr(pll_supervisor_pkg::ADDR_OUTSEL, (i == 0) ? 32'h00000101 : {16'h0000, seed});
      wr(4'hF, {seed, seed});
      rd(4'hF, rdv);
      chk("unmapped", 32'h00000000, rdv);
      chk("out3sel", (i == 0) ? pll_supervisor_pkg::OUTSEL_VCXO : seed[1:0], out3_vcxo_source_sel);
      chk("out4sel", (i == 0) ? 2'h1 : seed[9:8], out4VcxoSourceSel);
    end
    wr(pll_supervisor_pkg::ADDR_QUAL, 32'h00000005);
    wr(pll_supervisor_pkg::ADDR_DAC, {22'h000000, pll_supervisor_pkg::DAC_MID_CODE});
    settled <= 1'b1;
    refOk   <= 1'b1;
    repeat (12) @(posedge clk_sys);
    settled <= 1'b0;
    repeat (4) @(posedge clk_sys);
    settled <= 1'b1;
    repeat (20) @(negedge clk_sys);
    chk("lock early", 1'b0, lock_detect_out);
    foreach (cases[i])
    begin
      c = cases[i];
      wr(pll_supervisor_pkg::ADDR_IRQMASK, (i == 0) ? 32'h00000001 : 32'h0000000F);
      wr(pll_supervisor_pkg::ADDR_CTRL, {16'h0000, 8'h02, 3'b001, c[2], c[3], 1'b0, c[1:0]});
      @(posedge clk_sys);
      settled <= 1'b1;
      waitLock(1'b1);
      chk("lock", 1'b1, lock_detect_out);
      rd(pll_supervisor_pkg::ADDR_IRQSTAT, rdv);
      chk("irqstat relock", {prevHold, 3'b001}, rdv[3:0]);
      @(posedge clk_sys);
      refOk <= 1'b0;
      repeat (4) @(posedge clk_sys);
      settled <= 1'b0;
      waitLock(1'b0);
      chk("unlock", 1'b0, lock_detect_out);
      repeat (8) @(negedge clk_sys);
      chk("holdover", expHold(c), holdoverActive);
      rd(pll_supervisor_pkg::ADDR_STATUS, rdv);
      chk("status", {29'h0000000, 1'b0, expHold(c), 1'b0}, rdv);
      repeat (8) @(negedge clk_sys);
      if (expHold(c))
      begin
        chk("override", 1'b1, tuneDacOverride);
        chk("holdcode", pll_supervisor_pkg::DAC_MID_CODE, tuneDacCode);
      end
      chk("irq", (i == 0) ? 1'b0 : 1'b1, irq);
      rd(pll_supervisor_pkg::ADDR_IRQSTAT, rdv);
      chk("irqstat", expIrq(c), rdv[3:0]);
      chk("irq clear", 1'b0, irq);
      rd(pll_supervisor_pkg::ADDR_TRACKED, rdv);
      chk("tracked", {22'h000000, pll_supervisor_pkg::DAC_MID_CODE}, rdv);
      @(posedge clk_sys);
      refOk <= 1'b1;
      repeat (8) @(negedge clk_sys);
      chk("exit", 1'b0, holdoverActive);
      prevHold = expHold(c);
    end
    stop_test();
  end
endmodule
